// >>> hw/wdt_cfg.svh
// offsets, field positions, reset values and counts of the watchdog time-out unit
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register byte offsets, one aligned word each
`define WDT_OFF_CTRL      4'h0
`define WDT_OFF_PWR       4'h4
`define WDT_OFF_IRQ_STAT  4'h8
`define WDT_OFF_IRQ_MASK  4'hC

// watchdog_control fields
`define WDT_CTRL_EN_BIT   0
`define WDT_CTRL_PS_LSB   1
`define WDT_CTRL_PS_MSB   5
`define WDT_CTRL_RESET    8'h16
`define WDT_PS_RESET      5'h0B

// power_control_status fields
`define WDT_PWR_RST_BIT   0
`define WDT_PWR_EXP_BIT   1
`define WDT_PWR_PD_BIT    2

// interrupt status and mask fields
`define WDT_IRQ_RST_BIT   0
`define WDT_IRQ_WAKE_BIT  1
`define WDT_IRQ_W         2

// prescale: code 0 divides by 2**5, highest legal code 18
`define WDT_PS_BASE_TAP   5'h05
`define WDT_PS_MAX_CODE   5'h12
`define WDT_CNT_W         24

`endif

// >>> hw/wdt_pkg.sv
// types shared by the watchdog time-out unit
package wdt_pkg;
  // configuration enable mode
  typedef enum logic [1:0] {
    WDT_MODE_OFF   = 2'b00,
    WDT_MODE_SW    = 2'b01,
    WDT_MODE_AWAKE = 2'b10,
    WDT_MODE_ON    = 2'b11
  } wdt_mode_e;

  // power state of the core as seen by the watchdog
  typedef enum logic [0:0] {
    WDT_PWR_AWAKE = 1'b0,
    WDT_PWR_SLEEP = 1'b1
  } wdt_pwr_e;
endpackage

// >>> hw/wdt_sync.sv
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module wdt_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // asynchronous level in, synchronised level out
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_q; // first stage, read only by the second

  // ==========================================
  // two stages
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // wdt_sync
`default_nettype wire

// >>> hw/wdt_top.sv
// watchdog time-out unit: low-frequency counter, clear logic, flags, avalon slave
//
// Summary of operation
// - five-bit prescale, resets to 1:65536 code
// - code 0 is 1:32, each step doubles
// - codes 19..31 give minimum 1:32 interval
// - count cleared on reset, clear, sleep, failure
// - cleared entering sleep, counts, cleared leaving
// - expiry in sleep wakes, sets status flags
// - watchdog reset flag readable in power status
// - oscillator divider change leaves count alone
// - mode 01: software enable bit runs watchdog
// - software enable ignored in modes 1x, 00
// - held cleared: mode 00, 01 off, sleep 10
// - control: 7-6 zero, 5-1 prescale, 0 enable
// - intervals come from low-frequency oscillator ticks
// - cleared on exit sleep, any clock source
// - missed clear within period causes reset
// - mode 11 always on, 10 off asleep
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_top #(
  parameter int CNT_W = `WDT_CNT_W  // counter width, covers the largest tap
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // avalon-mm register slave
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output var  logic [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // configuration word
  input  wire wdt_pkg::wdt_mode_e config_watchdog_mode,
  // core events, one-cycle pulses
  input  wire logic               clear_watchdog_instruction,
  input  wire logic               sleep_enter,
  input  wire logic               sleep_exit,
  input  wire logic               osc_fail,
  // low-frequency oscillator pin
  input  wire logic               low_freq_internal_osc,
  // watchdog results
  output var  logic               watchdog_reset,
  output var  logic               wake_request,
  output var  logic               watchdog_active,
  output var  logic               expiry_flag,
  output var  logic               powerdown_flag,
  output logic                    irq
);
  import wdt_pkg::*;

  // ==========================================
  // helper functions

  // counter tap for a prescale code
  function automatic logic [4:0] ps_tap(input logic [4:0] code);
    if (code > `WDT_PS_MAX_CODE) begin
      ps_tap = `WDT_PS_BASE_TAP;
    end else begin
      ps_tap = code + `WDT_PS_BASE_TAP;
    end
  endfunction

  // true once the count has reached two to the power tap
  function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                   input logic [4:0]       tap);
    reached = |(cnt >> tap);
  endfunction

  // ==========================================
  // declarations
  logic             lf_sync;       // synchronised oscillator level
  logic             lf_prev_q;     // previous oscillator level
  logic             tick_w;        // one oscillator rising edge
  logic [CNT_W-1:0] cnt_q;         // watchdog count in oscillator ticks
  logic [CNT_W-1:0] cnt_d;         // next count
  logic [4:0]       ps_q;          // prescale select
  logic [4:0]       ps_d;          // next prescale select
  logic             swen_q;        // software enable
  logic             swen_d;        // next software enable
  wdt_pwr_e         pwr_q;         // awake or asleep
  wdt_pwr_e         pwr_d;         // next power state
  logic [4:0]       tap_w;         // selected tap
  logic             active_w;      // watchdog running
  logic             clr_req_w;     // clear event this cycle
  logic             cnt_clr_w;     // count goes to zero
  logic             expire_w;      // time-out this cycle
  logic             exp_awake_w;   // time-out while awake
  logic             exp_sleep_w;   // time-out while asleep
  logic             rst_flag_q;    // watchdog reset indication
  logic             rst_flag_d;    // next reset indication
  logic             exp_flag_d;    // next expiry flag
  logic             pd_flag_d;     // next power-down flag
  logic [`WDT_IRQ_W-1:0] stat_q;   // sticky interrupt status
  logic [`WDT_IRQ_W-1:0] stat_d;   // next status
  logic [`WDT_IRQ_W-1:0] stat_set; // events this cycle
  logic [`WDT_IRQ_W-1:0] mask_q;   // interrupt mask
  logic [`WDT_IRQ_W-1:0] mask_d;   // next mask
  logic             ack_q;         // bus answer cycle
  logic             req_w;         // bus request present
  logic             rd_acc;        // read accepted this edge
  logic             wr_acc;        // low byte write accepted this edge
  logic             sel_ctrl;      // control register hit
  logic             sel_pwr;       // power status hit
  logic             sel_stat;      // interrupt status hit
  logic             sel_mask;      // interrupt mask hit
  logic [31:0]      rd_mux;        // read data before register
  logic [7:0]       ctrl_rd;       // control register image
  logic [7:0]       pwr_rd;        // power status image
  logic             wr_ctrl_w;     // control write strobe
  logic             wr_pwr_w;      // power status write strobe
  logic             wr_mask_w;     // mask write strobe
  logic             rd_stat_w;     // status read strobe

  // ==========================================
  // oscillator crossing

  // the oscillator is far slower than sys_clk, so a plain two-flop
  // level crossing plus an edge detect loses no tick; each tick lands
  // about three system cycles after the pin edge
  // level crosses through two flops before use
  wdt_sync u_lf_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (low_freq_internal_osc),
    .sync_out (lf_sync)
  );

  // previous synchronised level for edge detect
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lf_prev_q <= 1'b0;
    end else begin
      lf_prev_q <= lf_sync;
    end
  end

  // each oscillator rising edge is one count
  assign tick_w = lf_sync & ~lf_prev_q;

  // ==========================================
  // enable decode

  // mode 11 always, 10 only awake, 01 by software, 00 never
  // the software enable only matters in mode 01
  assign active_w =
      (config_watchdog_mode == WDT_MODE_ON) |
      ((config_watchdog_mode == WDT_MODE_AWAKE) & (pwr_q == WDT_PWR_AWAKE)) |
      ((config_watchdog_mode == WDT_MODE_SW) & swen_q);

  // ==========================================
  // power state

  // sleep follows the core, a sleeping time-out wakes it
  // ending sleep here as well keeps the next sleep entry visible
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      WDT_PWR_AWAKE: begin
        if (sleep_enter) begin
          pwr_d = WDT_PWR_SLEEP;
        end
      end
      WDT_PWR_SLEEP: begin
        if (sleep_exit | exp_sleep_w) begin
          pwr_d = WDT_PWR_AWAKE;
        end
      end
      default: begin
        pwr_d = WDT_PWR_AWAKE;
      end
    endcase
  end

  // ==========================================
  // counter and expiry

  // hazard: a smaller prescale written while the count already sits
  // above the new tap expires on the next cycle; software should clear
  // first, then shrink the interval
  // selected tap from the prescale code
  assign tap_w = ps_tap(ps_q);

  // clear instruction, sleep entry and exit, oscillator failure;
  // a divider change in the clock unit is not a clear source
  assign clr_req_w = clear_watchdog_instruction | sleep_enter |
                     sleep_exit | osc_fail;

  // expiry when the tap is reached and no clear is pending
  assign expire_w    = active_w & reached(cnt_q, tap_w) & ~clr_req_w;
  assign exp_awake_w = expire_w & (pwr_q == WDT_PWR_AWAKE);
  assign exp_sleep_w = expire_w & (pwr_q == WDT_PWR_SLEEP);

  // disabled watchdog holds zero, expiry restarts the count
  assign cnt_clr_w = ~active_w | clr_req_w | expire_w;

  // binary count of oscillator ticks
  always_comb begin
    if (cnt_clr_w) begin
      cnt_d = '0;
    end else if (tick_w) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      cnt_d = cnt_q;
    end
  end

  // ==========================================
  // status flags

  // these flags are cleared by rst_n like everything else; if software must
  // see them after a watchdog reset, keep this block out of that reset
  // expiry flag: set by time-out, cleared by clear or sleep; set wins
  assign exp_flag_d = expire_w |
      (expiry_flag & ~(clear_watchdog_instruction | sleep_enter));
  // power-down flag: set by sleep entry, cleared by clear; set wins
  assign pd_flag_d  = sleep_enter | (powerdown_flag & ~clear_watchdog_instruction);
  // reset indication: set by time-out, write one to clear; set wins
  assign rst_flag_d = expire_w |
      (rst_flag_q & ~(wr_pwr_w & avs_writedata[`WDT_PWR_RST_BIT]));

  // ==========================================
  // interrupts

  // events: reset issued, wake issued
  assign stat_set[`WDT_IRQ_RST_BIT]  = exp_awake_w;
  assign stat_set[`WDT_IRQ_WAKE_BIT] = exp_sleep_w;
  // a read clears, an event in the same cycle survives
  assign stat_d = stat_set | (stat_q & ~{`WDT_IRQ_W{rd_stat_w}});
  // the mask only gates irq; status bits set whether masked or not
  // level while any unmasked bit is set
  assign irq = |(stat_q & mask_q);

  // ==========================================
  // avalon slave

  // every access answers after one wait cycle
  assign req_w           = avs_read | avs_write;
  assign avs_waitrequest = req_w & ~ack_q;
  assign rd_acc          = avs_read & ack_q;
  assign wr_acc          = avs_write & ack_q & avs_byteenable[0];
  // lanes above lane 0 carry no register bits and are ignored
  // one write strobe per register, taken at the accept edge
  assign wr_ctrl_w = wr_acc & sel_ctrl;
  assign wr_pwr_w  = wr_acc & sel_pwr;
  assign wr_mask_w = wr_acc & sel_mask;
  // status read, clears the sticky bits at the accept edge
  assign rd_stat_w = rd_acc & sel_stat;

  // word decode, others unmapped
  assign sel_ctrl = (avs_address == `WDT_OFF_CTRL);
  assign sel_pwr  = (avs_address == `WDT_OFF_PWR);
  assign sel_stat = (avs_address == `WDT_OFF_IRQ_STAT);
  assign sel_mask = (avs_address == `WDT_OFF_IRQ_MASK);

  // control image, top bits read zero
  assign ctrl_rd = {2'b00, ps_q, swen_q};
  // power status image
  assign pwr_rd  = {5'b0_0000, powerdown_flag, expiry_flag, rst_flag_q};

  // read selection, unmapped reads zero
  assign rd_mux = sel_ctrl ? {24'h00_0000, ctrl_rd} :
                  sel_pwr  ? {24'h00_0000, pwr_rd}  :
                  sel_stat ? {30'h0000_0000, stat_q} :
                  sel_mask ? {30'h0000_0000, mask_q} :
                  32'h0000_0000;

  // control writes: prescale and software enable
  assign ps_d   = wr_ctrl_w ?
                  avs_writedata[`WDT_CTRL_PS_MSB:`WDT_CTRL_PS_LSB] : ps_q;
  assign swen_d = wr_ctrl_w ?
                  avs_writedata[`WDT_CTRL_EN_BIT] : swen_q;
  // mask writes
  assign mask_d = wr_mask_w ? avs_writedata[`WDT_IRQ_W-1:0] : mask_q;

  // bus answer and read data registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= req_w & ~ack_q;
      if (avs_read & ~ack_q) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ==========================================
  // state registers

  // counter, power state and software registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      pwr_q  <= WDT_PWR_AWAKE;
      ps_q   <= `WDT_PS_RESET;
      swen_q <= 1'b0;
      mask_q <= '0;
    end else begin
      cnt_q  <= cnt_d;
      pwr_q  <= pwr_d;
      ps_q   <= ps_d;
      swen_q <= swen_d;
      mask_q <= mask_d;
    end
  end

  // flags and sticky status
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      expiry_flag    <= 1'b0;
      powerdown_flag <= 1'b0;
      rst_flag_q     <= 1'b0;
      stat_q         <= '0;
    end else begin
      expiry_flag    <= exp_flag_d;
      powerdown_flag <= pd_flag_d;
      rst_flag_q     <= rst_flag_d;
      stat_q         <= stat_d;
    end
  end

  // registered result outputs
  // registering gives the core clean one-cycle pulses with no glitches
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdog_reset  <= 1'b0;
      wake_request    <= 1'b0;
      watchdog_active <= 1'b0;
    end else begin
      watchdog_reset  <= exp_awake_w;
      wake_request    <= exp_sleep_w;
      watchdog_active <= active_w;
    end
  end

endmodule // wdt_top
`default_nettype wire

// >>> verification/wdt_top_props.sv
// concurrent checks on the ports of the watchdog time-out unit
`timescale 1ns/1ps
`default_nettype none
module wdt_top_props (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst_n,
  // register bus
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  // configuration and core events
  input wire wdt_pkg::wdt_mode_e config_watchdog_mode,
  input wire logic               sleep_enter,
  // watchdog results
  input wire logic               watchdog_reset,
  input wire logic               wake_request,
  input wire logic               watchdog_active,
  input wire logic               expiry_flag,
  input wire logic               powerdown_flag,
  input wire logic               irq
);
  import wdt_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // at most one wait cycle per request
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest) else $error("bus wait not one cycle");
  rd_upper_a: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h00_0000) else $error("read upper bits not zero");
  rst_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("reset pulse too long");
  wake_pulse_a: assert property (wake_request |=> !wake_request && !watchdog_reset)
    else $error("wake pulse too long");
  no_both_a: assert property (!(watchdog_reset && wake_request))
    else $error("reset and wake together");
  wake_flag_a: assert property (wake_request |-> ##[0:1] expiry_flag)
    else $error("wake without expiry flag");
  sleep_pd_a: assert property (sleep_enter |-> ##[1:2] powerdown_flag)
    else $error("sleep entry without powerdown flag");
  off_idle_a: assert property ((config_watchdog_mode == WDT_MODE_OFF) [*3] |->
    !watchdog_active && !watchdog_reset) else $error("watchdog runs in mode off");
  on_run_a: assert property ((config_watchdog_mode == WDT_MODE_ON) [*3] |->
    watchdog_active) else $error("watchdog idle in mode on");
  awake_sleep_a: assert property ((config_watchdog_mode == WDT_MODE_AWAKE) && sleep_enter
    |-> ##[2:3] !watchdog_active) else $error("mode awake runs in sleep");
  // main scenarios reached
  cov_reset_c: cover property (watchdog_reset);
  cov_wake_c: cover property (wake_request);
  cov_irq_c: cover property (irq);
endmodule // wdt_top_props
`default_nettype wire

// >>> verification/wdt_core_model.sv
// processor core model: oscillator pin and one-cycle core event pulses
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model #(
  parameter int OSC_HALF_NS = 43  // shortened oscillator half period
) (
  // clock
  input  wire logic sys_clk,
  // core events
  output logic      clear_watchdog_instruction,
  output logic      sleep_enter,
  output logic      sleep_exit,
  output logic      osc_fail,
  // oscillator pin
  output logic      low_freq_internal_osc
);
  logic [3:0] ev_q = 4'h0;  // pending event, one bit per kind
  // free-running oscillator, phase unrelated to sys_clk
  initial begin
    low_freq_internal_osc = 1'b0;
    forever #(OSC_HALF_NS) low_freq_internal_osc = ~low_freq_internal_osc;
  end
  assign {osc_fail, sleep_exit, sleep_enter, clear_watchdog_instruction} = ev_q;
  // one-cycle pulse launched at the next rising edge
  task automatic pulse(input logic [3:0] which);
    @(posedge sys_clk);
    ev_q <= which;
    @(posedge sys_clk);
    ev_q <= 4'h0;
  endtask
endmodule // wdt_core_model
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the watchdog time-out unit
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"
module tb_top;
  import wdt_pkg::*;
  logic        sys_clk = 1'b0;       // 125 MHz
  logic        rst_n = 1'b0;         // sync reset
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  wdt_mode_e   mode = WDT_MODE_OFF;  // configuration word
  logic        clr, slp_in, slp_out, ofail, losc;
  logic        wd_rst, wake, active, exp_f, pd_f, irq;
  logic [31:0] rd_q;                 // last read data
  logic [4:0]  codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
  int          ticks [4] = '{32, 64, 32, 32};
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;              // timeout counter
  int          rst_seen = 0;         // awake time-outs seen
  int          wake_seen = 0;        // sleep time-outs seen
  int          n;
  int          s;

  wdt_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .config_watchdog_mode(mode), .clear_watchdog_instruction(clr), .sleep_enter(slp_in),
    .sleep_exit(slp_out), .osc_fail(ofail), .low_freq_internal_osc(losc),
    .watchdog_reset(wd_rst), .wake_request(wake), .watchdog_active(active),
    .expiry_flag(exp_f), .powerdown_flag(pd_f), .irq(irq));
  wdt_core_model core_u (.sys_clk(sys_clk), .clear_watchdog_instruction(clr),
    .sleep_enter(slp_in), .sleep_exit(slp_out), .osc_fail(ofail),
    .low_freq_internal_osc(losc));

  always #4 sys_clk = ~sys_clk;
  // event counters and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (wd_rst === 1'b1) rst_seen++;
    if (wake === 1'b1) wake_seen++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= !we;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, rd_q, exp);
  endtask
  // no time-out of either kind over a quiet stretch
  task automatic quiet(input string nm);
    s = rst_seen + wake_seen;
    repeat (600) @(posedge sys_clk);
    chk(nm, rst_seen + wake_seen, s);
  endtask
  // core event, then time to the first time-out of either kind, whose kind is then checked
  task automatic run(input logic [3:0] ev, input int t, input logic [1:0] kind);
    core_u.pulse(ev);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wd_rst !== 1'b1 && wake !== 1'b1 && n < 3000);
    chk("interval", (n > t * 43 / 4 - 16) && (n < t * 43 / 4 + 16), 1'b1);
    chk("kind", {wake, wd_rst}, kind);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values and layout
    rreg(`WDT_OFF_CTRL, 8'h16, "ctrl");
    rreg(`WDT_OFF_PWR, 8'h00, "pwr");
    rreg(4'h2, 8'h00, "unmapped");
    bus(1'b1, `WDT_OFF_CTRL, 32'h0000_00FF);
    rreg(`WDT_OFF_CTRL, 8'h3F, "ctrl_bits");
    avs_byteenable <= 4'h0;
    bus(1'b1, `WDT_OFF_CTRL, 32'h0000_0000);
    avs_byteenable <= 4'hF;
    rreg(`WDT_OFF_CTRL, 8'h3F, "be_off");
    // off and software modes
    bus(1'b1, `WDT_OFF_CTRL, 8'h01);
    quiet("mode_off");
    chk("off_act", active, 1'b0);
    mode <= WDT_MODE_SW;
    bus(1'b1, `WDT_OFF_CTRL, 8'h00);
    quiet("sw_off");
    bus(1'b1, `WDT_OFF_CTRL, 8'h01);
    run(4'h1, 32, 2'b01);
    $display("test modes done");
    // prescale codes, legal and reserved, enable bit clear
    foreach (codes[i]) begin
      mode <= WDT_MODE_OFF;
      bus(1'b1, `WDT_OFF_CTRL, {codes[i], 1'b0});
      mode <= WDT_MODE_ON;
      run(4'h1, ticks[i], 2'b01);
    end
    chk("exp_flag", exp_f, 1'b1);
    rreg(`WDT_OFF_PWR, 8'h03, "pwr_rst");
    bus(1'b1, `WDT_OFF_PWR, 8'h01);
    rreg(`WDT_OFF_PWR, 8'h02, "pwr_w1c");
    rreg(`WDT_OFF_IRQ_STAT, 8'h01, "stat");
    rreg(`WDT_OFF_IRQ_STAT, 8'h00, "stat_rc");
    chk("irq_masked", irq, 1'b0);
    $display("test prescale done");
    // periodic clears and oscillator failure keep it quiet
    s = rst_seen;
    for (int i = 0; i < 6; i++) begin
      repeat (200) @(posedge sys_clk);
      core_u.pulse(i[0] ? 4'h1 : 4'h8);
    end
    chk("kick", rst_seen, s);
    chk("exp_clr", exp_f, 1'b0);
    $display("test kick done");
    // time-out in sleep wakes instead of resetting
    bus(1'b1, `WDT_OFF_IRQ_MASK, 8'h03);
    run(4'h2, 32, 2'b10);
    chk("pd_flag", pd_f, 1'b1);
    chk("exp_wake", exp_f, 1'b1);
    @(posedge sys_clk);
    chk("irq_set", irq, 1'b1);
    rreg(`WDT_OFF_IRQ_STAT, 8'h02, "stat_wake");
    @(posedge sys_clk);
    chk("irq_clr", irq, 1'b0);
    // mode awake stops in sleep and restarts on exit
    mode <= WDT_MODE_AWAKE;
    core_u.pulse(4'h2);
    quiet("awake_sleep");
    chk("sleep_act", active, 1'b0);
    core_u.pulse(4'h4);
    repeat (3) @(posedge sys_clk);
    chk("exit_act", active, 1'b1);
    // counting in sleep, then a full interval again after the exit
    mode <= WDT_MODE_ON;
    core_u.pulse(4'h2);
    repeat (200) @(posedge sys_clk);
    run(4'h4, 32, 2'b01);
    $display("test sleep done");
    give_verdict();
  end
endmodule // tb_top

bind wdt_top wdt_top_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .config_watchdog_mode(config_watchdog_mode), .sleep_enter(sleep_enter),
  .watchdog_reset(watchdog_reset), .wake_request(wake_request),
  .watchdog_active(watchdog_active), .expiry_flag(expiry_flag),
  .powerdown_flag(powerdown_flag), .irq(irq));
`default_nettype wire
